// ---- common/id_serial_powerdown_defs.svh ----
// Purpose: constants for the id / serial number / power-down command block
// Assumes: included by bare name; one core clock of 250 MHz
// Notes: opcodes, reset values and wake timing in one place
//
// Behaviour
// [RULE1] read-unique-id opcode returns eight fixed bytes, distinct per part, read only.
// [RULE2] dummy cycles before id and serial data follow the two latency code bits.
// [RULE3] unique id bytes leave lsb first; no wrap, data past byte eight undefined.
// [RULE4] host sends write-enable in its own frame before the serial write frame.
// [RULE5] serial write runs only with latch set; latch clears at frame end.
// [RULE6] serial write bytes are taken lsb first, msb last.
// [RULE7] exactly eight data bytes commit the serial write, otherwise it is dropped.
// [RULE8] serial bytes stored verbatim, no checksum computed by the device.
// [RULE9] serial number store resets to all zeros.
// [RULE10] host may lay out customer id, unique number and checksum as it likes.
// [RULE11] host bursts the serial read then stops clock and raises select.
// [RULE12] serial bytes leave lsb first; past byte eight data is undefined.
// [RULE13] opcode b9 enters deep power-down.
// [RULE14] opcode ba enters hibernate.
// [RULE15] opcode 66 arms reset, opcode 99 starts software reset.
// [RULE16] in deep power-down clock and data ignored, output released, select watched.
// [RULE17] select pulse or hard reset wakes after wake time, pins released meanwhile; code times the wake after a select pulse only, hard reset wakes at once.
// [RULE18] host may wake with a dummy command or select toggling alone.
// [RULE19] checksum and error registers are lost in deep power-down and read zero.
// [RULE20] write-enable latch reads cleared after deep power-down exit.
// [RULE21] falling select after hibernate starts wake that reloads all power-on defaults.
// [RULE22] any opcode other than 99 after 66 cancels the reset arm.
// [RULE23] opcodes decode in the active single, dual or quad protocol.
`ifndef ID_SERIAL_POWERDOWN_DEFS_SVH
`define ID_SERIAL_POWERDOWN_DEFS_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_READ_UNIQUE_ID 8'h4c
`define OP_SERIAL_WRITE 8'hc2
`define OP_SERIAL_READ 8'hc3
`define OP_DEEP_SLEEP 8'hb9
`define OP_HIBERNATE 8'hba
`define OP_RESET_ARM 8'h66
`define OP_RESET_GO 8'h99

`define SERIAL_RESET_VALUE 64'h0000000000000000
`define SERIAL_BYTES 4'h8
`define LATENCY_BASE 4'h0

`define CORE_CLK_MHZ 250
`define DEEP_SLEEP_WAKE_NS 10000
`define DEEP_SLEEP_PULSE_NS 100
`define HIBERNATE_WAKE_NS 450000
`define SOFT_RESET_NS 500
`define CEIL_CYCLES(ns) (((ns) * `CORE_CLK_MHZ + 999) / 1000)

`endif

// ---- common/id_serial_powerdown_pkg.sv ----
// Purpose: types for the id / serial number / power-down command block
// Assumes: nothing
// Notes: constants live in the defs header
package id_serial_powerdown_pkg;
  typedef enum logic [1:0] {
    PROTO_SINGLE,
    PROTO_DUAL,
    PROTO_QUAD
  } io_proto_t;

  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_DUMMY,
    PH_SEND,
    PH_TAKE,
    PH_IGNORE
  } frame_phase_t;

  typedef enum logic [2:0] {
    PWR_ACTIVE,
    PWR_DEEP_SLEEP,
    PWR_DEEP_WAKE,
    PWR_HIBERNATE,
    PWR_HIB_WAKE,
    PWR_SOFT_RESET
  } power_state_t;
endpackage

// ---- src/lane_sync.sv ----
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs asynchronous to i_core_clk
// Notes: first stage read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module lane_sync #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // both stages reset to a fixed idle pattern
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// ---- src/id_serial_powerdown_cmds.sv ----
// Purpose: serial command front end for unique id, user serial number and low-power entry
// Assumes: mode 0 sdr framing; host clock far slower than core clock
// Notes: pins are sampled by the core clock, edges found after synchronising
`include "id_serial_powerdown_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module id_serial_powerdown_cmds #(
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef, // arbitrary value
  parameter int DEEP_WAKE_CYCLES = `CEIL_CYCLES(`DEEP_SLEEP_WAKE_NS),
  parameter int HIB_WAKE_CYCLES = `CEIL_CYCLES(`HIBERNATE_WAKE_NS),
  parameter int SOFT_RESET_CYCLES = `CEIL_CYCLES(`SOFT_RESET_NS)
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // serial pins from host
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic [3:0] i_io,
  // serial pins to host, enable low while driving
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe_n,
  // configuration from neighbouring register logic
  input wire logic i_latency_code_bit0,
  input wire logic i_latency_code_bit1,
  input wire logic i_dual_io_protocol,
  input wire logic i_quad_io_protocol,
  input wire logic i_write_enable_latch,
  // state and effects toward neighbouring logic
  output logic o_write_enable_clear,
  output logic o_clear_ecc_crc,
  output logic o_reload_defaults,
  output logic o_soft_reset,
  output logic o_deep_sleep,
  output logic o_hibernate,
  output logic o_busy,
  output logic [63:0] o_user_serial_number
);
  localparam int PULSE_CYCLES = `CEIL_CYCLES(`DEEP_SLEEP_PULSE_NS);
  localparam int WAKE_MAX = (HIB_WAKE_CYCLES > DEEP_WAKE_CYCLES) ? HIB_WAKE_CYCLES : DEEP_WAKE_CYCLES;
  localparam int TW = $clog2(WAKE_MAX + 2);

  // synchronised pins
  logic [5:0] pins_s;
  logic cs_n_s, sck_s;
  logic [3:0] io_s;

  lane_sync #(.WIDTH(6)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_cs_n, i_sck, i_io}),
    .o_sync(pins_s)
  );
  assign cs_n_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign io_s = pins_s[3:0];

  // width in bits moved per clock for the active protocol
  function automatic logic [2:0] lane_bits(input id_serial_powerdown_pkg::io_proto_t p);
    case (p)
      id_serial_powerdown_pkg::PROTO_QUAD: lane_bits = 3'h4;
      id_serial_powerdown_pkg::PROTO_DUAL: lane_bits = 3'h2;
      default: lane_bits = 3'h1;
    endcase
  endfunction

  // state
  logic cs_n_q, sck_q;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [7:0] op_q, op_d;
  logic [3:0] bytecnt_q, bytecnt_d;
  logic [3:0] dummy_q, dummy_d;
  logic [63:0] src_q, src_d;
  logic [63:0] sn_q, sn_d;
  logic [63:0] snbuf_q, snbuf_d;
  logic armed_q, armed_d;
  logic [3:0] out_q, out_d;
  logic [3:0] oe_n_q, oe_n_d;
  logic wel_clr_q, wel_clr_d, clr_q, clr_d, reload_q, reload_d, srst_q, srst_d;
  id_serial_powerdown_pkg::frame_phase_t ph_q, ph_d;
  id_serial_powerdown_pkg::power_state_t pwr_q, pwr_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic ds_q, ds_d, hib_q, hib_d, busy_q, busy_d;
  id_serial_powerdown_pkg::io_proto_t proto;
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  logic [2:0] nb;
  logic [7:0] shifted;

  assign cs_fall = cs_n_q & ~cs_n_s;
  assign cs_rise = ~cs_n_q & cs_n_s;
  assign sck_rise = ~sck_q & sck_s;
  assign sck_fall = sck_q & ~sck_s;
  // opcode lanes follow the active protocol [RULE23]
  assign proto = i_quad_io_protocol ? id_serial_powerdown_pkg::PROTO_QUAD :
                 i_dual_io_protocol ? id_serial_powerdown_pkg::PROTO_DUAL :
                 id_serial_powerdown_pkg::PROTO_SINGLE;
  assign nb = lane_bits(proto);

  // opcode arrives msb first; data bytes lsb first, so data is reversed on load
  always_comb begin
    case (proto)
      id_serial_powerdown_pkg::PROTO_QUAD: shifted = {sh_q[3:0], io_s};
      id_serial_powerdown_pkg::PROTO_DUAL: shifted = {sh_q[5:0], io_s[1:0]};
      default: shifted = {sh_q[6:0], io_s[0]};
    endcase
  end

  // reverse bit order of a byte
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction

  // next-state for frame decode, power modes and data paths
  always_comb begin
    sh_d = sh_q;
    bitcnt_d = bitcnt_q;
    op_d = op_q;
    bytecnt_d = bytecnt_q;
    dummy_d = dummy_q;
    src_d = src_q;
    sn_d = sn_q;
    snbuf_d = snbuf_q;
    armed_d = armed_q;
    out_d = out_q;
    oe_n_d = oe_n_q;
    ph_d = ph_q;
    pwr_d = pwr_q;
    tmr_d = tmr_q;
    wel_clr_d = 1'b0;
    clr_d = 1'b0;
    reload_d = 1'b0;
    srst_d = 1'b0;
    case (pwr_q)
      id_serial_powerdown_pkg::PWR_ACTIVE: begin
        if (cs_n_s) begin
          oe_n_d = 4'hf;
        end
        if (cs_fall) begin
          ph_d = id_serial_powerdown_pkg::PH_OPCODE;
          bitcnt_d = 4'h0;
          bytecnt_d = 4'h0;
          sh_d = 8'h00;
        end else if (cs_rise) begin
          ph_d = id_serial_powerdown_pkg::PH_IGNORE;
          if (op_q == `OP_SERIAL_WRITE && ph_q != id_serial_powerdown_pkg::PH_OPCODE) begin
            if (i_write_enable_latch && bytecnt_q == `SERIAL_BYTES && bitcnt_q == 4'h0) begin // [RULE5] [RULE7]
              sn_d = snbuf_q; // stored verbatim, no checksum [RULE8]
            end
            wel_clr_d = 1'b1; // [RULE5]
          end
          if (op_q == `OP_DEEP_SLEEP && ph_q == id_serial_powerdown_pkg::PH_IGNORE) begin
            pwr_d = id_serial_powerdown_pkg::PWR_DEEP_SLEEP; // [RULE13] [RULE16]
            oe_n_d = 4'hf;
          end
          if (op_q == `OP_HIBERNATE && ph_q == id_serial_powerdown_pkg::PH_IGNORE) begin
            pwr_d = id_serial_powerdown_pkg::PWR_HIBERNATE; // [RULE14]
            oe_n_d = 4'hf;
          end
          op_d = 8'h00;
        end else if (!cs_n_s && sck_rise) begin
          case (ph_q)
            id_serial_powerdown_pkg::PH_OPCODE: begin
              sh_d = shifted;
              bitcnt_d = bitcnt_q + {1'b0, nb};
              if (bitcnt_q + {1'b0, nb} == 4'h8) begin
                op_d = shifted;
                bitcnt_d = 4'h0;
                ph_d = id_serial_powerdown_pkg::PH_IGNORE;
                dummy_d = `LATENCY_BASE + {2'b00, i_latency_code_bit1, i_latency_code_bit0}; // [RULE2]
                // every opcode but the reset arm itself clears the arm, reset go included [RULE22]
                armed_d = (shifted == `OP_RESET_ARM);
                case (shifted)
                  `OP_READ_UNIQUE_ID: begin
                    src_d = UNIQUE_ID; // [RULE1]
                    ph_d = id_serial_powerdown_pkg::PH_DUMMY;
                  end
                  `OP_SERIAL_READ: begin
                    src_d = sn_q;
                    ph_d = id_serial_powerdown_pkg::PH_DUMMY;
                  end
                  `OP_SERIAL_WRITE: ph_d = id_serial_powerdown_pkg::PH_TAKE;
                  `OP_RESET_GO: begin
                    if (armed_q) begin
                      srst_d = 1'b1; // [RULE15]
                      clr_d = 1'b1;
                      wel_clr_d = 1'b1;
                      pwr_d = id_serial_powerdown_pkg::PWR_SOFT_RESET;
                      tmr_d = TW'(SOFT_RESET_CYCLES);
                    end
                  end
                  default: ;
                endcase
              end
            end
            id_serial_powerdown_pkg::PH_TAKE: begin
              // lsb first into the serial buffer [RULE6]
              sh_d = shifted;
              bitcnt_d = bitcnt_q + {1'b0, nb};
              if (bitcnt_q + {1'b0, nb} == 4'h8) begin
                bitcnt_d = 4'h0;
                if (bytecnt_q < `SERIAL_BYTES) begin
                  snbuf_d = {rev8(shifted), snbuf_q[63:8]};
                end
                bytecnt_d = (bytecnt_q == 4'hf) ? 4'hf : bytecnt_q + 4'h1; // [RULE7]
              end
            end
            id_serial_powerdown_pkg::PH_DUMMY: begin
              if (dummy_q == 4'h0) begin
                ph_d = id_serial_powerdown_pkg::PH_SEND;
              end else begin
                dummy_d = dummy_q - 4'h1;
              end
            end
            default: ;
          endcase
        end else if (!cs_n_s && sck_fall && ph_q == id_serial_powerdown_pkg::PH_SEND) begin
          // first bit leaves on the fall after the last dummy rise [RULE2]
          // lsb first, no wrap: zeros shift in past byte eight [RULE3] [RULE12]
          ph_d = id_serial_powerdown_pkg::PH_SEND;
          case (proto)
            id_serial_powerdown_pkg::PROTO_QUAD: begin
              out_d = src_q[3:0];
              src_d = {4'h0, src_q[63:4]};
              oe_n_d = 4'h0;
            end
            id_serial_powerdown_pkg::PROTO_DUAL: begin
              out_d = {2'b00, src_q[1:0]};
              src_d = {2'b00, src_q[63:2]};
              oe_n_d = 4'hc;
            end
            default: begin
              out_d = {2'b00, src_q[0], 1'b0};
              src_d = {1'b0, src_q[63:1]};
              oe_n_d = 4'hd;
            end
          endcase
        end
      end
      id_serial_powerdown_pkg::PWR_DEEP_SLEEP: begin
        // clock and data ignored, only select is watched [RULE16]
        oe_n_d = 4'hf;
        if (!cs_n_s) begin
          tmr_d = (tmr_q == TW'(PULSE_CYCLES)) ? tmr_q : tmr_q + TW'(1);
        end else if (tmr_q >= TW'(PULSE_CYCLES)) begin
          pwr_d = id_serial_powerdown_pkg::PWR_DEEP_WAKE; // [RULE17] [RULE18]
          tmr_d = TW'(DEEP_WAKE_CYCLES);
        end else begin
          tmr_d = '0;
        end
      end
      id_serial_powerdown_pkg::PWR_DEEP_WAKE: begin
        oe_n_d = 4'hf; // pins released during wake [RULE17]
        tmr_d = tmr_q - TW'(1);
        if (tmr_q == TW'(1)) begin
          pwr_d = id_serial_powerdown_pkg::PWR_ACTIVE;
          clr_d = 1'b1; // [RULE19]
          wel_clr_d = 1'b1; // [RULE20]
          ph_d = id_serial_powerdown_pkg::PH_IGNORE;
        end
      end
      id_serial_powerdown_pkg::PWR_HIBERNATE: begin
        oe_n_d = 4'hf;
        if (cs_fall) begin
          pwr_d = id_serial_powerdown_pkg::PWR_HIB_WAKE; // [RULE21]
          tmr_d = TW'(HIB_WAKE_CYCLES);
        end
      end
      id_serial_powerdown_pkg::PWR_HIB_WAKE: begin
        oe_n_d = 4'hf;
        tmr_d = tmr_q - TW'(1);
        if (tmr_q == TW'(1)) begin
          pwr_d = id_serial_powerdown_pkg::PWR_ACTIVE;
          reload_d = 1'b1; // all registers back to power-on values [RULE21]
          clr_d = 1'b1;
          wel_clr_d = 1'b1;
          sn_d = `SERIAL_RESET_VALUE;
          armed_d = 1'b0;
          ph_d = id_serial_powerdown_pkg::PH_IGNORE;
        end
      end
      id_serial_powerdown_pkg::PWR_SOFT_RESET: begin
        oe_n_d = 4'hf;
        tmr_d = tmr_q - TW'(1);
        if (tmr_q <= TW'(1)) begin
          pwr_d = id_serial_powerdown_pkg::PWR_ACTIVE;
          armed_d = 1'b0;
          ph_d = id_serial_powerdown_pkg::PH_IGNORE;
        end
      end
      default: pwr_d = id_serial_powerdown_pkg::PWR_ACTIVE;
    endcase
    // mode flags taken from the next state so the outputs come from flops
    ds_d = (pwr_d == id_serial_powerdown_pkg::PWR_DEEP_SLEEP);
    hib_d = (pwr_d == id_serial_powerdown_pkg::PWR_HIBERNATE);
    busy_d = (pwr_d != id_serial_powerdown_pkg::PWR_ACTIVE);
  end

  // register everything; serial store resets to zero [RULE9]
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      sh_q <= 8'h00;
      bitcnt_q <= 4'h0;
      op_q <= 8'h00;
      bytecnt_q <= 4'h0;
      dummy_q <= 4'h0;
      src_q <= 64'h0000000000000000;
      sn_q <= `SERIAL_RESET_VALUE;
      snbuf_q <= 64'h0000000000000000;
      armed_q <= 1'b0;
      out_q <= 4'h0;
      oe_n_q <= 4'hf;
      wel_clr_q <= 1'b0;
      clr_q <= 1'b0;
      reload_q <= 1'b0;
      srst_q <= 1'b0;
      ph_q <= id_serial_powerdown_pkg::PH_IGNORE;
      pwr_q <= id_serial_powerdown_pkg::PWR_ACTIVE;
      tmr_q <= '0;
      ds_q <= 1'b0;
      hib_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      sck_q <= sck_s;
      sh_q <= sh_d;
      bitcnt_q <= bitcnt_d;
      op_q <= op_d;
      bytecnt_q <= bytecnt_d;
      dummy_q <= dummy_d;
      src_q <= src_d;
      sn_q <= sn_d;
      snbuf_q <= snbuf_d;
      armed_q <= armed_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      wel_clr_q <= wel_clr_d;
      clr_q <= clr_d;
      reload_q <= reload_d;
      srst_q <= srst_d;
      ph_q <= ph_d;
      pwr_q <= pwr_d;
      tmr_q <= tmr_d;
      ds_q <= ds_d;
      hib_q <= hib_d;
      busy_q <= busy_d;
    end
  end

  // outputs straight from flops; mode flags are registered decodes of the next state
  assign o_io = out_q;
  assign o_io_oe_n = oe_n_q;
  assign o_write_enable_clear = wel_clr_q;
  assign o_clear_ecc_crc = clr_q;
  assign o_reload_defaults = reload_q;
  assign o_soft_reset = srst_q;
  assign o_deep_sleep = ds_q;
  assign o_hibernate = hib_q;
  assign o_busy = busy_q;
  assign o_user_serial_number = sn_q;
endmodule
`default_nettype wire

// ---- verification/id_serial_powerdown_cmds_sva.sv ----
// Purpose: port-level checks for the id, serial number and power-down block
// Assumes: one core clock domain, active-low async reset
// Notes: pin edges reach the core a few cycles late, hence the slack in windows
`timescale 1ns/100ps
`default_nettype none
module id_serial_powerdown_cmds_sva (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // watched pins and state
  input wire logic i_cs_n,
  input wire logic i_write_enable_latch,
  input wire logic [3:0] o_io_oe_n,
  input wire logic o_soft_reset,
  input wire logic o_reload_defaults,
  input wire logic o_deep_sleep,
  input wire logic o_hibernate,
  input wire logic o_busy,
  input wire logic [63:0] o_user_serial_number
);
  // all checks share the core clock and reset
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  idle_release_a: assert property (i_cs_n [*7] |-> o_io_oe_n == 4'hf)
    else $error("pins driven while deselected");
  sleep_quiet_a: assert property ((o_deep_sleep || o_hibernate) |-> o_io_oe_n == 4'hf)
    else $error("pins driven in a low power state");
  wake_quiet_a: assert property (o_busy [*2] |-> o_io_oe_n == 4'hf)
    else $error("pins driven while busy");
  busy_decode_a: assert property ((o_deep_sleep || o_hibernate) |-> o_busy && !(o_deep_sleep && o_hibernate))
    else $error("power state flags inconsistent");
  power_entry_a: assert property ($rose(o_deep_sleep || o_hibernate) |-> $past(i_cs_n, 2))
    else $error("low power entered before select rose");
  deep_exit_a: assert property ($fell(o_deep_sleep) |-> i_cs_n)
    else $error("deep sleep left while selected");
  hib_wake_a: assert property ($fell(o_hibernate) |-> !i_cs_n)
    else $error("hibernate left without falling select");
  sn_commit_a: assert property ($changed(o_user_serial_number) && o_user_serial_number != 64'h0
    |-> i_cs_n && $past(i_write_enable_latch, 3))
    else $error("serial store changed outside an enabled frame end");
  reset_pulse_a: assert property (o_soft_reset |-> o_busy ##1 !o_soft_reset)
    else $error("soft reset pulse malformed");
  reload_zero_a: assert property (o_reload_defaults |-> ##[0:2] o_user_serial_number == 64'h0)
    else $error("serial store not reloaded after hibernate");
endmodule
`default_nettype wire

// ---- verification/spi_host_model.sv ----
// Purpose: serial host driving select, clock and data on one lane, or on two or four for bare opcodes
// Assumes: mode 0; one serial period is 20 core cycles (80 ns)
// Notes: clock stands low between frames; a released line reads inverted
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // core clock
  input wire logic i_clk,
  // device output lines
  input wire logic [3:0] i_io,
  input wire logic [3:0] i_io_oe_n,
  // host pins
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_io
);
  logic so_q;
  logic so;

  // never let a released line look like valid data
  assign so = i_io_oe_n[1] ? ~so_q : i_io[1];
  always @(posedge i_clk) begin
    so_q <= so;
    if (o_cs_n) o_io <= ~o_io;
  end

  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_io = 4'h0;
  end

  // one period: data set while clock low, both sides sample at the rise
  task automatic bit_cyc(input logic b, output logic r);
    o_io[0] <= b;
    repeat (10) @(posedge i_clk);
    r = so;
    o_sck <= 1'b1;
    repeat (10) @(posedge i_clk);
    o_sck <= 1'b0;
  endtask

  // opcode msb first, data bytes lsb first, dummies, then read bits lsb first
  task automatic frame(input logic [7:0] op, input int nwr, input logic [63:0] wd,
                       input int ndum, input int nrd, output logic [63:0] rd);
    logic r;
    rd = 64'h0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    @(posedge i_clk);
    for (int i = 7; i >= 0; i--) bit_cyc(op[i], r);
    for (int i = 0; i < nwr * 8; i++) bit_cyc(wd[i % 64], r);
    for (int i = 0; i < ndum; i++) bit_cyc(1'b0, r);
    for (int i = 0; i < nrd; i++) begin
      bit_cyc(1'b0, r);
      rd[i] = r;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask

  // opcode alone on two or four lanes, most significant group first
  task automatic wide_op(input logic [7:0] op, input int w);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    @(posedge i_clk);
    for (int i = 8 - w; i >= 0; i -= w) begin
      o_io <= (w == 4) ? op[i +: 4] : {2'b00, op[i +: 2]};
      repeat (10) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (10) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask

  // select toggled alone, clock left still
  task automatic cs_pulse(input int cyc);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (cyc) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the id, serial number and power-down block
// Assumes: single lane protocol except the closing dual and quad opcodes; wake counts shortened by parameters
// Notes: the bench plays the status logic that owns the write-enable latch
`include "id_serial_powerdown_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [63:0] UID = 64'h5a3c96e10f78b2d4; // arbitrary value
  logic clk, rst_n, cs_n, sck, lat0, lat1, write_enable_latch, dual, quad;
  logic [3:0] hio, dio, oe_n;
  logic wec, clr, rel, srst, ds, hib, busy;
  logic [63:0] sn;
  int error_cnt = 0;
  int cmp_count = 0;
  int n_clr = 0;
  int n_rel = 0;
  int n_srst = 0;

  id_serial_powerdown_cmds #(.UNIQUE_ID(UID), .DEEP_WAKE_CYCLES(8), .HIB_WAKE_CYCLES(8),
    .SOFT_RESET_CYCLES(4)) uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
    .i_io(hio), .o_io(dio), .o_io_oe_n(oe_n), .i_latency_code_bit0(lat0), .i_latency_code_bit1(lat1),
    .i_dual_io_protocol(dual), .i_quad_io_protocol(quad), .i_write_enable_latch(write_enable_latch),
    .o_write_enable_clear(wec), .o_clear_ecc_crc(clr), .o_reload_defaults(rel), .o_soft_reset(srst),
    .o_deep_sleep(ds), .o_hibernate(hib), .o_busy(busy), .o_user_serial_number(sn));
  spi_host_model host (.i_clk(clk), .i_io(dio), .i_io_oe_n(oe_n), .o_cs_n(cs_n), .o_sck(sck), .o_io(hio));

  // pulse tally and the latch clear, as neighbouring logic would do
  always @(posedge clk) begin
    if (wec) write_enable_latch <= 1'b0;
    if (clr) n_clr <= n_clr + 1;
    if (rel) n_rel <= n_rel + 1;
    if (srst) n_srst <= n_srst + 1;
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // host-side layout: id and number on top, xor checksum in the low byte
  function automatic logic [63:0] make_sn(input logic [55:0] body);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 7; i++) c ^= body[i*8 +: 8];
    return {body, c};
  endfunction

  // store takes a whole eight-byte write only with the latch set
  function automatic logic [63:0] sn_after(input logic [63:0] old, input logic [63:0] wd,
                                           input int nb, input logic en);
    return (en && nb == 8) ? wd : old;
  endfunction

  // run length bounded well above the planned traffic
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    results;
  end

  initial begin
    logic [63:0] rd, wd, exp_sn;
    int nb, lat, c0;
    logic en;
    rst_n = 1'b0;
    lat0 = 1'b0;
    lat1 = 1'b0;
    write_enable_latch = 1'b0;
    dual = 1'b0;
    quad = 1'b0;
    exp_sn = 64'h0;
    void'($urandom(6358));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(sn, 64'h0);
    // id read at every latency code
    for (int l = 0; l < 4; l++) begin
      {lat1, lat0} <= 2'(l);
      host.frame(`OP_READ_UNIQUE_ID, 0, 64'h0, l + 1, 64, rd);
      chk(rd, UID);
    end
    // writes: enabled, latch clear, seven bytes, nine bytes, enabled again
    for (int k = 0; k < 5; k++) begin
      nb = (k == 2) ? 7 : (k == 3) ? 9 : 8;
      en = (k != 1);
      wd = make_sn(56'({$urandom, $urandom}));
      if (en) begin
        host.frame(`OP_WRITE_ENABLE, 0, 64'h0, 0, 0, rd);
        write_enable_latch <= 1'b1;
      end
      host.frame(`OP_SERIAL_WRITE, nb, wd, 0, 0, rd);
      exp_sn = sn_after(exp_sn, wd, nb, en);
      chk(sn, exp_sn);
      chk(64'(write_enable_latch), 64'h0);
      lat = $urandom_range(3);
      {lat1, lat0} <= 2'(lat);
      host.frame(`OP_SERIAL_READ, 0, 64'h0, lat + 1, 64, rd);
      chk(rd, exp_sn);
    end
    // deep sleep: a write frame is ignored, and its select pulse wakes
    write_enable_latch <= 1'b1;
    c0 = n_clr;
    host.frame(`OP_DEEP_SLEEP, 0, 64'h0, 0, 0, rd);
    chk(64'({ds, busy}), 64'h3);
    host.frame(`OP_SERIAL_WRITE, 8, ~exp_sn, 0, 0, rd);
    chk(sn, exp_sn);
    chk(64'({ds, busy, write_enable_latch}), 64'h0);
    chk(64'(n_clr - c0), 64'h1);
    host.frame(`OP_DEEP_SLEEP, 0, 64'h0, 0, 0, rd);
    host.cs_pulse(30);
    chk(64'({ds, busy}), 64'h0);
    // hibernate: falling select wakes and reloads defaults
    host.frame(`OP_HIBERNATE, 0, 64'h0, 0, 0, rd);
    chk(64'({hib, busy}), 64'h3);
    host.cs_pulse(30);
    chk(64'({hib, busy}), 64'h0);
    chk(64'(n_rel), 64'h1);
    chk(sn, 64'h0);
    // arm then reset, and an arm broken by another opcode
    host.frame(`OP_RESET_ARM, 0, 64'h0, 0, 0, rd);
    host.frame(`OP_RESET_GO, 0, 64'h0, 0, 0, rd);
    chk(64'(n_srst), 64'h1);
    host.frame(`OP_RESET_ARM, 0, 64'h0, 0, 0, rd);
    host.frame(`OP_WRITE_ENABLE, 0, 64'h0, 0, 0, rd);
    host.frame(`OP_RESET_GO, 0, 64'h0, 0, 0, rd);
    chk(64'(n_srst), 64'h1);
    // hardware reset also ends deep sleep
    host.frame(`OP_DEEP_SLEEP, 0, 64'h0, 0, 0, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(64'({ds, busy}), 64'h0);
    // low power opcodes sent on four and on two lanes
    quad <= 1'b1;
    host.wide_op(`OP_HIBERNATE, 4);
    chk(64'({hib, busy}), 64'h3);
    host.cs_pulse(30);
    {dual, quad} <= 2'b10;
    host.wide_op(`OP_DEEP_SLEEP, 2);
    chk(64'({ds, busy}), 64'h3);
    host.cs_pulse(30);
    chk(64'({ds, hib, busy}), 64'h0);
    results;
  end
endmodule

bind id_serial_powerdown_cmds id_serial_powerdown_cmds_sva sva_i (.i_core_clk, .i_rst_n, .i_cs_n,
  .i_write_enable_latch, .o_io_oe_n, .o_soft_reset, .o_reload_defaults, .o_deep_sleep, .o_hibernate,
  .o_busy, .o_user_serial_number);
`default_nettype wire
